// File: ouart_pkg.sv
// Shared constants and carriers for the octal UART I/O register decode
package ouart_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_CHAN = 8;
  localparam int ADDR_W = 6;
  localparam logic [5:0] CHAN_STRIDE = 6'h08;

  // ----------------------------------------------------------------
  // Byte offsets inside one channel block
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IRQ_EN = 3'h1;
  localparam logic [2:0] OFS_IRQ_ST = 3'h2;
  localparam logic [2:0] OFS_LINE_CTL = 3'h3;
  localparam logic [2:0] OFS_MODEM_CTL = 3'h4;
  localparam logic [2:0] OFS_LINE_ST = 3'h5;
  localparam logic [2:0] OFS_MODEM_ST = 3'h6;
  localparam logic [2:0] OFS_SPECIAL = 3'h7;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int DIV_ACCESS_BIT = 7;
  localparam int RX_AVAIL_EN_BIT = 0;
  localparam int DATA_READY_BIT = 0;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Software controlled settings of one channel
  typedef struct packed {
    logic [7:0] irq_enable;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] special_function;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [7:0] sample_clock;
  } ouart_cfg_t;

  // Status reported by the serial side of one channel
  typedef struct packed {
    logic [7:0] irq_status;
    logic [7:0] line_state;
    logic [7:0] modem_state;
  } ouart_stat_t;

  localparam ouart_cfg_t CFG_RST = '0;

  // Channel number from a BAR0-relative address
  function automatic logic [2:0] chan_of(input logic [5:0] addr);
    chan_of = addr[5:3];
  endfunction

  // Byte offset inside the channel block
  function automatic logic [2:0] ofs_of(input logic [5:0] addr);
    ofs_of = addr[2:0];
  endfunction

endpackage

// File: ouart_chan.sv
// Register block of one UART channel
`timescale 1ns/10ps
module ouart_chan (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [2:0] ofs_i,
  input wire logic [7:0] wdata_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire ouart_pkg::ouart_stat_t stat_i,
  output ouart_pkg::ouart_cfg_t cfg_o,
  output logic [7:0] rdata_o,
  output logic tx_load_o,
  output logic [7:0] tx_data_o,
  output logic qc_load_o,
  output logic [7:0] qc_data_o,
  output logic rx_irq_o
);

  ouart_pkg::ouart_cfg_t cfg_q;
  logic [7:0] rx_q;
  logic rx_ready_q;
  logic dlab;
  logic [7:0] lstate;

  // Divisor bank switch follows the line control bit directly
  assign dlab = cfg_q.line_control[ouart_pkg::DIV_ACCESS_BIT];

  // ----------------------------------------------------------------
  // Settings writes; read-only offsets swallow writes silently
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_q <= ouart_pkg::CFG_RST;
    end else if (wr_i) begin
      case (ofs_i)
        ouart_pkg::OFS_DATA: begin
          if (dlab) begin
            cfg_q.divisor_low <= wdata_i;
          end
        end
        ouart_pkg::OFS_IRQ_EN: begin
          if (dlab) begin
            cfg_q.divisor_high <= wdata_i;
          end else begin
            cfg_q.irq_enable <= wdata_i;
          end
        end
        ouart_pkg::OFS_IRQ_ST: begin
          if (dlab) begin
            cfg_q.sample_clock <= wdata_i;
          end
        end
        ouart_pkg::OFS_LINE_CTL: cfg_q.line_control <= wdata_i;
        ouart_pkg::OFS_MODEM_CTL: cfg_q.modem_control <= wdata_i;
        ouart_pkg::OFS_SPECIAL: cfg_q.special_function <= wdata_i;
        default: begin
        end
      endcase
    end
  end

  // Transmit holding byte, with a one-cycle load pulse
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_data_o <= ouart_pkg::BYTE_RST;
      tx_load_o <= 1'b0;
    end else begin
      tx_load_o <= wr_i && ofs_i == ouart_pkg::OFS_DATA && !dlab;
      if (wr_i && ofs_i == ouart_pkg::OFS_DATA && !dlab) begin
        tx_data_o <= wdata_i;
      end
    end
  end

  // Queue control write goes out as value plus pulse
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      qc_data_o <= ouart_pkg::BYTE_RST;
      qc_load_o <= 1'b0;
    end else begin
      qc_load_o <= wr_i && ofs_i == ouart_pkg::OFS_IRQ_ST && !dlab;
      if (wr_i && ofs_i == ouart_pkg::OFS_IRQ_ST && !dlab) begin
        qc_data_o <= wdata_i;
      end
    end
  end

  // Received byte; a new arrival beats the clear by a read
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_q <= ouart_pkg::BYTE_RST;
      rx_ready_q <= 1'b0;
    end else begin
      if (rx_valid_i) begin
        rx_q <= rx_data_i;
        rx_ready_q <= 1'b1;
      end else if (rd_i && ofs_i == ouart_pkg::OFS_DATA && !dlab) begin
        rx_ready_q <= 1'b0;
      end
    end
  end

  // Data-ready flag merged into the line state for polling hosts
  always_comb begin
    lstate = stat_i.line_state;
    lstate[ouart_pkg::DATA_READY_BIT] = stat_i.line_state[ouart_pkg::DATA_READY_BIT] | rx_ready_q;
  end

  // ----------------------------------------------------------------
  // Read multiplexer, registered by the decoder
  // ----------------------------------------------------------------
  always_comb begin
    unique case (ofs_i)
      ouart_pkg::OFS_DATA: rdata_o = dlab ? cfg_q.divisor_low : rx_q;
      ouart_pkg::OFS_IRQ_EN: rdata_o = dlab ? cfg_q.divisor_high : cfg_q.irq_enable;
      ouart_pkg::OFS_IRQ_ST: rdata_o = dlab ? cfg_q.sample_clock : stat_i.irq_status;
      ouart_pkg::OFS_LINE_CTL: rdata_o = cfg_q.line_control;
      ouart_pkg::OFS_MODEM_CTL: rdata_o = cfg_q.modem_control;
      ouart_pkg::OFS_LINE_ST: rdata_o = lstate;
      ouart_pkg::OFS_MODEM_ST: rdata_o = stat_i.modem_state;
      ouart_pkg::OFS_SPECIAL: rdata_o = cfg_q.special_function;
    endcase
  end

  // Interrupt held off unless receive-available is enabled
  assign rx_irq_o = rx_ready_q & cfg_q.irq_enable[ouart_pkg::RX_AVAIL_EN_BIT];
  assign cfg_o = cfg_q;

endmodule

// File: ouart_decode.sv
// Top-level I/O register decode for eight UART channels
// Operation
// - Each channel owns an eight-byte register block.
// - Channel n block starts at n times 08h.
// - Decode enable, line, modem, status, special offsets.
// - Offset 00h reads rx, writes tx.
// - Offset 02h reads irq status, writes queue control.
// - Divisor-access bit maps divisor and sample-clock registers.
// - Received byte read-only, resets to 00h.
// - Transmit holding byte written, resets to 00h.
// - Receive interrupt blocked while enable bit clear.
// - Enable bit permits interrupt, resets cleared.
`timescale 1ns/10ps
module ouart_decode (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [5:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_rd_ack_o,
  input wire logic [7:0] rx_valid_i,
  input wire logic [7:0][7:0] rx_data_i,
  input wire ouart_pkg::ouart_stat_t [7:0] stat_i,
  output ouart_pkg::ouart_cfg_t [7:0] cfg_o,
  output logic [7:0] tx_load_o,
  output logic [7:0][7:0] tx_data_o,
  output logic [7:0] qc_load_o,
  output logic [7:0][7:0] qc_data_o,
  output logic [7:0] rx_irq_o
);

  // ----------------------------------------------------------------
  // Address split
  // ----------------------------------------------------------------
  logic [2:0] sel_ch;
  logic [2:0] sel_ofs;
  logic [7:0] ch_wr;
  logic [7:0] ch_rd;
  logic [7:0][7:0] ch_rdata;
  logic sel_dlab;

  // Upper bits pick the channel, so blocks sit 08h apart
  assign sel_ch = ouart_pkg::chan_of(io_addr_i);
  assign sel_ofs = ouart_pkg::ofs_of(io_addr_i);
  assign sel_dlab = cfg_o[sel_ch].line_control[ouart_pkg::DIV_ACCESS_BIT];

  // One-hot strobes; the whole 64-byte window is mapped, no holes
  always_comb begin
    ch_wr = '0;
    ch_rd = '0;
    ch_wr[sel_ch] = io_wr_i;
    ch_rd[sel_ch] = io_rd_i;
  end

  // ----------------------------------------------------------------
  // Channel register blocks
  // ----------------------------------------------------------------
  for (genvar c = 0; c < ouart_pkg::NUM_CHAN; c++) begin : g_chan
    ouart_chan u_chan (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .wr_i(ch_wr[c]),
      .rd_i(ch_rd[c]),
      .ofs_i(sel_ofs),
      .wdata_i(io_wdata_i),
      .rx_valid_i(rx_valid_i[c]),
      .rx_data_i(rx_data_i[c]),
      .stat_i(stat_i[c]),
      .cfg_o(cfg_o[c]),
      .rdata_o(ch_rdata[c]),
      .tx_load_o(tx_load_o[c]),
      .tx_data_o(tx_data_o[c]),
      .qc_load_o(qc_load_o[c]),
      .qc_data_o(qc_data_o[c]),
      .rx_irq_o(rx_irq_o[c])
    );
  end

  // ----------------------------------------------------------------
  // Read return
  // ----------------------------------------------------------------

  // Registered so the host sees data one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      io_rdata_o <= ouart_pkg::BYTE_RST;
      io_rd_ack_o <= 1'b0;
    end else begin
      io_rd_ack_o <= io_rd_i;
      if (io_rd_i) begin
        io_rdata_o <= ch_rdata[sel_ch];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks on the decode
  // ----------------------------------------------------------------
  a_read_ack_time: assert property (@(posedge clk_i) disable iff (srst_i)
    io_rd_i |=> io_rd_ack_o ##1 (io_rd_ack_o == $past(io_rd_i)))
    else $error("read answer not one cycle after strobe");

  a_irq_en_read: assert property (@(posedge clk_i) disable iff (srst_i)
    io_rd_i && !io_wr_i && sel_ofs == ouart_pkg::OFS_IRQ_EN && !sel_dlab
    |=> io_rdata_o == $past(cfg_o[sel_ch].irq_enable))
    else $error("interrupt enable readback wrong");

  a_line_ctl_write: assert property (@(posedge clk_i) disable iff (srst_i)
    io_wr_i && sel_ofs == ouart_pkg::OFS_LINE_CTL
    |=> cfg_o[$past(sel_ch)].line_control == $past(io_wdata_i))
    else $error("line control write lost");

  a_tx_load_path: assert property (@(posedge clk_i) disable iff (srst_i)
    io_wr_i && sel_ofs == ouart_pkg::OFS_DATA && !sel_dlab
    |=> tx_load_o == (8'h01 << $past(sel_ch)) && tx_data_o[$past(sel_ch)] == $past(io_wdata_i))
    else $error("transmit holding not loaded");

  a_tx_held_div: assert property (@(posedge clk_i) disable iff (srst_i)
    io_wr_i && sel_ofs == ouart_pkg::OFS_DATA && sel_dlab
    |=> tx_load_o == 8'h00 && cfg_o[$past(sel_ch)].divisor_low == $past(io_wdata_i))
    else $error("divisor write leaked to transmit");

  a_qc_load_path: assert property (@(posedge clk_i) disable iff (srst_i)
    io_wr_i && sel_ofs == ouart_pkg::OFS_IRQ_ST && !sel_dlab
    |=> qc_load_o[$past(sel_ch)] && qc_data_o[$past(sel_ch)] == $past(io_wdata_i)
      && cfg_o[$past(sel_ch)].sample_clock == $past(cfg_o[sel_ch].sample_clock))
    else $error("queue control write misrouted");

  a_status_read: assert property (@(posedge clk_i) disable iff (srst_i)
    io_rd_i && sel_ofs == ouart_pkg::OFS_IRQ_ST && !sel_dlab
    |=> io_rdata_o == $past(stat_i[sel_ch].irq_status))
    else $error("interrupt status readback wrong");

  a_sample_read: assert property (@(posedge clk_i) disable iff (srst_i)
    io_rd_i && !io_wr_i && sel_ofs == ouart_pkg::OFS_IRQ_ST && sel_dlab
    |=> io_rdata_o == $past(cfg_o[sel_ch].sample_clock))
    else $error("sample clock readback wrong");

  a_rx_read_data: assert property (@(posedge clk_i) disable iff (srst_i)
    io_rd_i && sel_ofs == ouart_pkg::OFS_DATA && !sel_dlab && !rx_valid_i[sel_ch]
    ##1 io_rd_i && io_addr_i == $past(io_addr_i) && !rx_valid_i[sel_ch]
    |=> io_rdata_o == $past(io_rdata_o))
    else $error("received byte changed without arrival");

  a_reset_values: assert property (@(posedge clk_i)
    srst_i |=> tx_data_o == '0 && rx_irq_o == 8'h00 && tx_load_o == 8'h00
      && io_rd_ack_o == 1'b0 && cfg_o == '0)
    else $error("reset values wrong");

  // ----------------------------------------------------------------
  // Checks on the shared, read-only and control offsets, and per-channel checks
  // ----------------------------------------------------------------
  // Bank switch must steer a 01h write to exactly one of its two homes
  a_irq_en_write: assert property (@(posedge clk_i) disable iff (srst_i)
    io_wr_i && sel_ofs == ouart_pkg::OFS_IRQ_EN && !sel_dlab
    |=> cfg_o[$past(sel_ch)].irq_enable == $past(io_wdata_i)
      && cfg_o[$past(sel_ch)].divisor_high == $past(cfg_o[sel_ch].divisor_high))
    else $error("interrupt enable write misrouted");

  a_div_high_write: assert property (@(posedge clk_i) disable iff (srst_i)
    io_wr_i && sel_ofs == ouart_pkg::OFS_IRQ_EN && sel_dlab
    |=> cfg_o[$past(sel_ch)].divisor_high == $past(io_wdata_i)
      && cfg_o[$past(sel_ch)].irq_enable == $past(cfg_o[sel_ch].irq_enable))
    else $error("divisor high write misrouted");

  a_qc_held_div: assert property (@(posedge clk_i) disable iff (srst_i)
    io_wr_i && sel_ofs == ouart_pkg::OFS_IRQ_ST && sel_dlab
    |=> qc_load_o == 8'h00 && cfg_o[$past(sel_ch)].sample_clock == $past(io_wdata_i))
    else $error("sample clock write leaked to queue control");

  a_div_low_read: assert property (@(posedge clk_i) disable iff (srst_i)
    io_rd_i && !io_wr_i && sel_ofs == ouart_pkg::OFS_DATA && sel_dlab
    |=> io_rdata_o == $past(cfg_o[sel_ch].divisor_low))
    else $error("divisor low readback wrong");

  // Status offsets have no storage behind them, so a write must vanish
  a_ro_write_drop: assert property (@(posedge clk_i) disable iff (srst_i)
    io_wr_i && (sel_ofs == ouart_pkg::OFS_LINE_ST || sel_ofs == ouart_pkg::OFS_MODEM_ST)
    |=> cfg_o == $past(cfg_o) && tx_load_o == 8'h00 && qc_load_o == 8'h00)
    else $error("write to status offset took effect");

  a_line_st_read: assert property (@(posedge clk_i) disable iff (srst_i)
    io_rd_i && sel_ofs == ouart_pkg::OFS_LINE_ST
    |=> io_rdata_o[7:1] == $past(stat_i[sel_ch].line_state[7:1]))
    else $error("line state readback wrong");

  a_modem_st_read: assert property (@(posedge clk_i) disable iff (srst_i)
    io_rd_i && sel_ofs == ouart_pkg::OFS_MODEM_ST
    |=> io_rdata_o == $past(stat_i[sel_ch].modem_state))
    else $error("modem state readback wrong");

  a_modem_ctl_read: assert property (@(posedge clk_i) disable iff (srst_i)
    io_rd_i && !io_wr_i && sel_ofs == ouart_pkg::OFS_MODEM_CTL
    |=> io_rdata_o == $past(cfg_o[sel_ch].modem_control))
    else $error("modem control readback wrong");

  a_special_read: assert property (@(posedge clk_i) disable iff (srst_i)
    io_rd_i && !io_wr_i && sel_ofs == ouart_pkg::OFS_SPECIAL
    |=> io_rdata_o == $past(cfg_o[sel_ch].special_function))
    else $error("special function readback wrong");

  a_rx_read_clear: assert property (@(posedge clk_i) disable iff (srst_i)
    io_rd_i && sel_ofs == ouart_pkg::OFS_DATA && !sel_dlab && !rx_valid_i[sel_ch]
    |=> !rx_irq_o[$past(sel_ch)])
    else $error("receive interrupt stayed after read");

  for (genvar k = 0; k < ouart_pkg::NUM_CHAN; k++) begin : g_chk
    a_irq_gate: assert property (@(posedge clk_i) disable iff (srst_i)
      !cfg_o[k].irq_enable[ouart_pkg::RX_AVAIL_EN_BIT] |-> !rx_irq_o[k])
      else $error("receive interrupt raised while disabled");

    a_irq_permit: assert property (@(posedge clk_i) disable iff (srst_i)
      rx_valid_i[k] && cfg_o[k].irq_enable[ouart_pkg::RX_AVAIL_EN_BIT] && !ch_wr[k]
      |=> rx_irq_o[k])
      else $error("enabled receive interrupt missing");

    a_div_retained: assert property (@(posedge clk_i) disable iff (srst_i)
      $fell(cfg_o[k].line_control[ouart_pkg::DIV_ACCESS_BIT])
      |-> $stable(cfg_o[k].divisor_low) && $stable(cfg_o[k].divisor_high)
        && $stable(cfg_o[k].sample_clock))
      else $error("divisor lost when bank closed");

    a_block_isolate: assert property (@(posedge clk_i) disable iff (srst_i)
      io_wr_i && sel_ch != k |=> $stable(cfg_o[k]) && !tx_load_o[k] && !qc_load_o[k])
      else $error("write touched another channel");
  end

endmodule

// File: ouart_serial_model.sv
// Serial-side model: received bytes and status levels for all channels
`timescale 1ns/10ps
module ouart_serial_model (
  input wire logic clk_i,
  output logic [7:0] rx_valid_o,
  output logic [7:0][7:0] rx_data_o,
  output ouart_pkg::ouart_stat_t [7:0] stat_o
);
  // Interrupt and modem status differ per channel so that aliasing between blocks shows
  initial begin
    rx_valid_o = 8'h00;
    for (int c = 0; c < 8; c++) begin
      rx_data_o[c] = 8'hA5;
      stat_o[c] = {8'hC0 | 8'(c), 8'h60, 8'hB0 | 8'(c)};
    end
  end

  // One byte for one cycle; afterwards the line shows the inverse, not a stale copy
  task automatic push(input int ch, input logic [7:0] b);
    rx_valid_o[ch] = 1'b1;
    rx_data_o[ch] = b;
    @(posedge clk_i);
    #2;
    rx_valid_o[ch] = 1'b0;
    rx_data_o[ch] = ~b;
  endtask
endmodule

// File: testbench.sv
// Self-checking bench for the octal UART register decode
`timescale 1ns/10ps
`define CHECK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module testbench;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [5:0] io_addr = 6'h00;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic io_rd_ack;
  logic [7:0] rx_valid;
  logic [7:0][7:0] rx_data;
  ouart_pkg::ouart_stat_t [7:0] stat;
  ouart_pkg::ouart_cfg_t [7:0] cfg;
  logic [7:0] tx_load;
  logic [7:0][7:0] tx_data;
  logic [7:0] qc_load;
  logic [7:0][7:0] qc_data;
  logic [7:0] rx_irq;
  int n_mismatch = 0;
  int total_checks = 0;

  // ----------------------------------------------------------------
  // Clock, design and serial side
  // ----------------------------------------------------------------
  always #25 clk_i = ~clk_i;

  ouart_decode dut (.clk_i(clk_i), .srst_i(srst_i), .io_addr_i(io_addr), .io_wr_i(io_wr),
    .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .io_rd_ack_o(io_rd_ack),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .stat_i(stat), .cfg_o(cfg),
    .tx_load_o(tx_load), .tx_data_o(tx_data), .qc_load_o(qc_load), .qc_data_o(qc_data),
    .rx_irq_o(rx_irq));

  ouart_serial_model serial (.clk_i(clk_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .stat_o(stat));

  // ----------------------------------------------------------------
  // Bus tasks: strobes held until the next task, so none toggles in one step
  // ----------------------------------------------------------------
  function automatic logic [5:0] ad_of(input int c, input logic [2:0] o);
    return ouart_pkg::CHAN_STRIDE * 6'(c) + 6'(o); // Block stride of eight bytes
  endfunction

  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    io_addr = ad;
    io_wdata = d;
    io_wr = 1'b1;
    io_rd = 1'b0;
    @(posedge clk_i);
    #2;
  endtask

  task automatic rd_chk(input logic [5:0] ad, input logic [7:0] exp, input string nm);
    io_addr = ad;
    io_rd = 1'b1;
    io_wr = 1'b0;
    @(posedge clk_i);
    #2;
    `CHECK({nm, " ack"}, 1'b1, io_rd_ack)
    `CHECK(nm, exp, io_rdata)
  endtask

  task automatic idle();
    io_wr = 1'b0;
    io_rd = 1'b0;
    @(posedge clk_i);
    #2;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int c = 0; c < 8; c++) begin
      rd_chk(ad_of(c, ouart_pkg::OFS_DATA), 8'h00, "rx_holding");
      rd_chk(ad_of(c, ouart_pkg::OFS_IRQ_EN), 8'h00, "irq_enable");
      `CHECK("tx_holding", 8'h00, tx_data[c])
      `CHECK("cfg", ouart_pkg::CFG_RST, cfg[c])
    end
    `CHECK("rx_irq", 8'h00, rx_irq)
    $display("test reset done");
  endtask

  // All blocks written first, then read: a shared block would show
  task automatic t_map();
    for (int c = 0; c < 8; c++) begin
      wr(ad_of(c, 3'h1), 8'h20 | 8'(c * 2));
      wr(ad_of(c, 3'h3), 8'h03);
      wr(ad_of(c, 3'h4), 8'h40 | 8'(c));
      wr(ad_of(c, 3'h7), 8'h70 | 8'(c));
      wr(ad_of(c, 3'h5), 8'hFF); // Read-only places ignore writes
      wr(ad_of(c, 3'h6), 8'hFF);
    end
    for (int c = 0; c < 8; c++) begin
      rd_chk(ad_of(c, 3'h1), 8'h20 | 8'(c * 2), "irq_enable");
      rd_chk(ad_of(c, 3'h2), 8'hC0 | 8'(c), "irq_status");
      rd_chk(ad_of(c, 3'h3), 8'h03, "line_control");
      rd_chk(ad_of(c, 3'h4), 8'h40 | 8'(c), "modem_control");
      rd_chk(ad_of(c, 3'h5), 8'h60, "line_state");
      rd_chk(ad_of(c, 3'h6), 8'hB0 | 8'(c), "modem_state");
      rd_chk(ad_of(c, 3'h7), 8'h70 | 8'(c), "special_function");
      `CHECK("cfg modem", 8'h40 | 8'(c), cfg[c].modem_control)
    end
    $display("test map done");
  endtask

  // Back-to-back writes to the shared offsets of every channel
  task automatic t_tx();
    for (int c = 0; c < 8; c++) begin
      wr(ad_of(c, 3'h0), 8'h41 + 8'(c));
      `CHECK("tx_load", 8'h01 << c, tx_load)
      `CHECK("tx_holding", 8'h41 + 8'(c), tx_data[c])
      wr(ad_of(c, 3'h2), 8'h81 + 8'(c));
      `CHECK("qc_load", 8'h01 << c, qc_load)
      `CHECK("tx_load", 8'h00, tx_load)
      `CHECK("queue_control", 8'h81 + 8'(c), qc_data[c])
      `CHECK("sample_clock", 8'h00, cfg[c].sample_clock)
    end
    $display("test tx done");
  endtask

  task automatic t_div();
    wr(ad_of(3, 3'h3), 8'h83);
    wr(ad_of(3, 3'h0), 8'h12);
    `CHECK("tx_load", 8'h00, tx_load)
    wr(ad_of(3, 3'h1), 8'h34);
    wr(ad_of(3, 3'h2), 8'h56);
    `CHECK("qc_load", 8'h00, qc_load)
    rd_chk(ad_of(3, 3'h0), 8'h12, "divisor_low");
    rd_chk(ad_of(3, 3'h1), 8'h34, "divisor_high");
    rd_chk(ad_of(3, 3'h2), 8'h56, "sample_clock");
    wr(ad_of(3, 3'h3), 8'h03);
    rd_chk(ad_of(3, 3'h1), 8'h26, "irq_enable");
    rd_chk(ad_of(3, 3'h2), 8'hC3, "irq_status");
    `CHECK("divisors", 24'h123456, {cfg[3].divisor_low, cfg[3].divisor_high,
      cfg[3].sample_clock})
    `CHECK("tx_holding", 8'h44, tx_data[3])
    `CHECK("cfg irq_enable", 8'h26, cfg[3].irq_enable)
    $display("test divisor done");
  endtask

  // Receive path with the interrupt first masked, then enabled
  task automatic t_rx();
    wr(ad_of(5, 3'h1), 8'h00);
    idle();
    serial.push(5, 8'h5A);
    idle();
    `CHECK("rx_irq masked", 8'h00, rx_irq)
    rd_chk(ad_of(5, 3'h5), 8'h61, "line_state ready");
    rd_chk(ad_of(5, 3'h0), 8'h5A, "rx_holding");
    rd_chk(ad_of(5, 3'h5), 8'h60, "line_state clear");
    wr(ad_of(5, 3'h1), 8'h01);
    idle();
    serial.push(5, 8'hC3);
    idle();
    `CHECK("rx_irq enabled", 8'h20, rx_irq)
    rd_chk(ad_of(5, 3'h0), 8'hC3, "rx_holding");
    rd_chk(ad_of(5, 3'h0), 8'hC3, "rx_holding again");
    idle();
    `CHECK("rx_irq after read", 8'h00, rx_irq)
    $display("test rx done");
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence after sixteen cycles of reset
  initial begin
    repeat (16) @(posedge clk_i);
    #2;
    srst_i = 1'b0;
    t_reset();
    t_map();
    t_tx();
    t_div();
    t_rx();
    idle();
    give_verdict();
  end

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #(50 * 4000);
    n_mismatch++;
    $display("Error watchdog expected end seen hang");
    give_verdict();
  end
endmodule
